// file: dbg_bus_completer.sv
`timescale 1ns/10ps
// How it works
// R1: all transfers timed on bus clock rising edges
// R2: active-low reset idles the bus interface
// R3: word address; unused upper bits ignored
// R4: requester gives each completer its own select
// R5: enable low first cycle, high afterwards
// R6: direction high is write, low is read
// R7: requester drives write data, up to 32 bits
// R8: completer drives read data on reads
// R9: completer stalls by holding ready low
// R10: error shown in second cycle, with completion
// R11: error only when component is unavailable
// R12: off: ready, error high; read data low
// R13: off requester clamps its outputs low
// R14: 32-bit bus, registers take 32-bit accesses
// R15: 8/16/32 data path, no pipelining
// R16: address bit 31 has no special meaning
// R17: other access paths keep bus access complete
// R18: no registers means no port needed
// R19: requester holds controls until ready
// R20: writes and read data only at completion
module dbg_bus_completer
  import dbg_port_pkg::*;
(
  input wire logic CLOCK, // debug bus clock, 10 MHz
  input wire logic RSTN, // async reset, active low
  input wire logic [31:2] DBG_BUS_ADDR, // word address
  input wire logic DBG_BUS_SEL, // this completer selected
  input wire logic DBG_BUS_ACCESS_PHASE, // second and later cycles
  input wire logic DBG_BUS_DIR_WRITE, // high write, low read
  input wire logic [31:0] DBG_BUS_WR_DATA, // write data
  input wire logic DBG_COMP_OFF, // component powered down or disabled
  output logic DBG_BUS_RDY, // transfer may complete
  output logic [31:0] DBG_BUS_RD_DATA, // read data
  output logic DBG_BUS_ERR // unavailable response
);
  logic rst_s1; // reset release stage one
  logic rst_n; // released reset copy
  logic off_s1; // power-off sync stage one
  logic off_s2; // power-off sync stage two
  logic off_s3; // power-off sync stage three
  logic off; // filtered power-off level
  xfer_state_t state; // transfer sequencer
  xfer_state_t next_state; // sequencer next value
  logic setup; // setup phase seen
  logic complete; // completing access cycle
  logic mem_we; // register write strobe
  logic [BUS_DATA_W-1:0] mem_rdata; // store read word
  logic [BUS_DATA_W-1:0] rd_q; // read data flop
  logic [REG_IDX_W-1:0] idx; // implemented word index

  // narrow a word to the built data path, upper bits zero
  function automatic logic [31:0] dpath_mask(input logic [31:0] d);
    logic [31:0] m;
    m = (DPATH_W >= 32) ? 32'hffff_ffff
                        : ((32'h1 << DPATH_W) - 32'h1);
    return d & m;
  endfunction

  // reset release through two flops, assert stays asynchronous
  always_ff @(posedge CLOCK or negedge RSTN) begin // [R2]
    if (!RSTN) begin
      rst_s1 <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_s1 <= 1'h1;
      rst_n <= rst_s1;
    end
  end

  // power-off pin comes from another domain: three flops
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      off_s1 <= 1'h0;
      off_s2 <= 1'h0;
      off_s3 <= 1'h0;
    end else begin
      off_s1 <= DBG_COMP_OFF;
      off_s2 <= off_s1;
      off_s3 <= off_s2;
    end
  end

  // a level change counts once stages two and three agree
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      off <= 1'h0;
    end else if (off_s2 == off_s3) begin
      off <= off_s3;
    end
  end

  // upper address bits, bit 31 included, are simply not decoded
  assign idx = DBG_BUS_ADDR[ADDR_LSB+REG_IDX_W-1:ADDR_LSB]; // [R3] [R16]
  // setup phase: select without enable; the requester keeps
  // address and direction until ready
  assign setup = DBG_BUS_SEL && !DBG_BUS_ACCESS_PHASE; // [R5] [R19]
  assign complete = (state == ST_DONE) && DBG_BUS_SEL
                    && DBG_BUS_ACCESS_PHASE;
  // writes land only in the completing cycle
  assign mem_we = complete && DBG_BUS_DIR_WRITE && !off; // [R6] [R20]

  // register words; read issued from the setup address
  // the bus port is the only way in, so no debug state hides
  // behind some other access path [R17]
  // the store is why this port exists at all [R18]
  dbg_reg_store u_store (
    .clk(CLOCK),
    .rst_n(rst_n),
    .we(mem_we),
    .waddr(idx),
    .wdata(dpath_mask(DBG_BUS_WR_DATA)), // [R7] [R14] [R15]
    .raddr(idx),
    .rdata(mem_rdata)
  );

  // sequencer: one wait state, then complete; no overlap
  always_comb begin // [R9] [R15]
    next_state = state;
    case (state)
      ST_IDLE: begin
        // start only when the component is there
        if (setup && !off) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_state = ST_DONE;
      end
      ST_DONE: begin
        // one transfer ends before the next setup is taken
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // going off abandons the transfer; clamps finish it
    if (off) begin
      next_state = ST_IDLE;
    end
  end

  // sequencer state, idle from reset
  always_ff @(posedge CLOCK or negedge rst_n) begin // [R1] [R2]
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // read data captured in the wait cycle, cleared afterwards so
  // the bus only carries data in the completing cycle
  always_ff @(posedge CLOCK or negedge rst_n) begin // [R8] [R20]
    if (!rst_n) begin
      rd_q <= RD_DATA_RESET;
    end else if (state == ST_WAIT && !DBG_BUS_DIR_WRITE && !off) begin
      rd_q <= dpath_mask(mem_rdata);
    end else begin
      rd_q <= RD_DATA_RESET;
    end
  end

  // outputs; clamps override everything while off
  always_comb begin // [R12]
    if (off) begin
      DBG_BUS_RDY = RDY_CLAMP;
      DBG_BUS_ERR = ERR_CLAMP; // [R10] [R11]
      DBG_BUS_RD_DATA = RD_DATA_CLAMP;
    end else begin
      // ready held low in idle and wait stalls the access
      DBG_BUS_RDY = (state == ST_DONE); // [R9]
      DBG_BUS_ERR = 1'h0; // [R11]
      DBG_BUS_RD_DATA = rd_q;
    end
  end

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  property p_clamp;
    off |-> DBG_BUS_RDY && DBG_BUS_ERR && (DBG_BUS_RD_DATA == 32'h0);
  endproperty
  a_clamp: assert property (p_clamp) // [R12]
    else $error("clamp values wrong while off");

  property p_err_only_off;
    DBG_BUS_ERR |-> off;
  endproperty
  a_err_only_off: assert property (p_err_only_off) // [R11]
    else $error("error raised while available");

  property p_err_second;
    (setup && off) ##1 off |-> DBG_BUS_ERR && DBG_BUS_RDY;
  endproperty
  a_err_second: assert property (p_err_second) // [R10]
    else $error("error not given in second cycle");

  property p_stall;
    (state == ST_IDLE && setup && !off) ##1 !off |-> !DBG_BUS_RDY
      ##1 (off || DBG_BUS_RDY);
  endproperty
  a_stall: assert property (p_stall) // [R9]
    else $error("ready timing wrong after setup");

  property p_no_pipe;
    state == ST_DONE |=> state == ST_IDLE;
  endproperty
  a_no_pipe: assert property (p_no_pipe) // [R15]
    else $error("transfers overlap");

  property p_wr_at_done;
    mem_we |-> DBG_BUS_RDY && DBG_BUS_SEL && DBG_BUS_ACCESS_PHASE
      && DBG_BUS_DIR_WRITE;
  endproperty
  a_wr_at_done: assert property (p_wr_at_done) // [R20]
    else $error("write outside completing cycle");

  property p_rd_only_done;
    (DBG_BUS_RD_DATA != 32'h0) |-> (state == ST_DONE) && !off;
  endproperty
  a_rd_only_done: assert property (p_rd_only_done) // [R20]
    else $error("read data outside completion");

  property p_rd_source;
    (state == ST_WAIT && !off && !DBG_BUS_DIR_WRITE) ##1 !off
      |-> DBG_BUS_RD_DATA == $past(mem_rdata);
  endproperty
  a_rd_source: assert property (p_rd_source) // [R8]
    else $error("read data not from addressed word");

  property p_reset_idle;
    $rose(rst_n) |-> state == ST_IDLE && !DBG_BUS_RDY;
  endproperty
  a_reset_idle: assert property (p_reset_idle) // [R2]
    else $error("not idle after reset");

  // a taken setup moves straight to the stall cycle
  property p_setup_taken;
    (state == ST_IDLE) && setup && !off |=> state == ST_WAIT;
  endproperty
  a_setup_taken: assert property (p_setup_taken) // [R15]
    else $error("setup not taken from idle");

  // the stall cycle holds ready low while the component is available
  property p_wait_low;
    (state == ST_WAIT) && !off |-> !DBG_BUS_RDY;
  endproperty
  a_wait_low: assert property (p_wait_low) // [R9]
    else $error("ready high in stall cycle");

  // one stall cycle only, then the completing cycle
  property p_wait_done;
    (state == ST_WAIT) && !off |=> state == ST_DONE;
  endproperty
  a_wait_done: assert property (p_wait_done) // [R9]
    else $error("stall longer than one cycle");

  // ready stands for the completing cycle only
  property p_rdy_one;
    DBG_BUS_RDY && !off |=> !DBG_BUS_RDY || off;
  endproperty
  a_rdy_one: assert property (p_rdy_one) // [R15]
    else $error("ready held past completion");

  // idle and available: no ready, no data on the bus
  property p_idle_quiet;
    (state == ST_IDLE) && !off
      |-> !DBG_BUS_RDY && (DBG_BUS_RD_DATA == 32'h0);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // [R20]
    else $error("bus not quiet while idle");

  // a write completion never carries read data
  property p_rd_zero_write;
    complete && DBG_BUS_DIR_WRITE |-> DBG_BUS_RD_DATA == 32'h0;
  endproperty
  a_rd_zero_write: assert property (p_rd_zero_write) // [R8]
    else $error("read data driven on a write");

  // nothing lands in the store while off
  property p_no_write_off;
    off |-> !mem_we;
  endproperty
  a_no_write_off: assert property (p_no_write_off) // [R12]
    else $error("write landed while off");

  // while off the sequencer sits in idle, so a transfer
  // cut short by power-down is never resumed later
  property p_off_idle;
    off |=> state == ST_IDLE;
  endproperty
  a_off_idle: assert property (p_off_idle) // [R12]
    else $error("sequencer left idle while off");

  // filtered level follows stage three once two and three agree
  property p_off_filter;
    off_s2 == off_s3 |=> off == $past(off_s3);
  endproperty
  a_off_filter: assert property (p_off_filter) // [R12]
    else $error("power-off filter out of step");

  // main scenarios: write, read, off answer, stall, aliased address
  c_write: cover property (mem_we);
  c_read: cover property (complete && !DBG_BUS_DIR_WRITE && !off);
  c_off_err: cover property (setup && off ##1 DBG_BUS_ERR);
  c_stall: cover property (state == ST_WAIT && !off);
  c_alias: cover property (complete && DBG_BUS_ADDR[31]);
endmodule

// file: dbg_port_pkg.sv
package dbg_port_pkg;
  // bus geometry
  localparam int BUS_DATA_W = 32;     // debug bus data width
  localparam int DPATH_W = 32;        // built data path: 8, 16 or 32
  localparam int ADDR_LSB = 2;        // word address starts here
  localparam int REG_IDX_W = 4;       // implemented word index bits
  localparam int REG_DEPTH = 16;      // words in the register store
  // reset values and clamp levels
  localparam logic [31:0] RD_DATA_RESET = 32'h0000_0000;
  localparam logic [31:0] RD_DATA_CLAMP = 32'h0000_0000;
  localparam logic RDY_CLAMP = 1'h1;
  localparam logic ERR_CLAMP = 1'h1;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // transfer sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // no transfer, or setup phase
    ST_WAIT = 2'b01,  // first access cycle, stalled
    ST_DONE = 2'b10   // completing cycle, ready high
  } xfer_state_t;
endpackage

// file: dbg_reg_store.sv
`timescale 1ns/10ps
module dbg_reg_store
  import dbg_port_pkg::*;
(
  input wire logic clk, // bus clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic we, // write strobe
  input wire logic [REG_IDX_W-1:0] waddr, // write word index
  input wire logic [BUS_DATA_W-1:0] wdata, // write data
  input wire logic [REG_IDX_W-1:0] raddr, // read word index
  output logic [BUS_DATA_W-1:0] rdata // registered read data
);
  logic [BUS_DATA_W-1:0] mem [REG_DEPTH]; // register words

  // storage, cleared at reset so reads never return unknowns
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem[i] <= REG_RESET;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= REG_RESET;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// file: dbg_requester.sv
`timescale 1ns/10ps
module dbg_requester (
  input wire logic clk, // bus clock
  output logic [31:2] addr, // word address
  output logic sel, // select
  output logic acc, // access phase
  output logic wr, // write direction
  output logic [31:0] wdata, // write data
  input wire logic rdy, // ready
  input wire logic [31:0] rdata, // read data
  input wire logic err // error
);
  // quiet bus at start, controls low
  initial begin
    {addr, sel, acc, wr, wdata} = '0;
  end
  // one whole transfer; waits counts stalled access cycles
  task automatic xfer(input logic w, input logic [31:2] a,
    input logic [31:0] d, output logic [31:0] rd, output logic e,
    output int waits);
    waits = 0;
    @(posedge clk) #1;
    sel = 1'h1; // own select line
    acc = 1'h0; // setup cycle
    wr = w; // high write, low read
    addr = a;
    wdata = d; // driven for writes
    @(posedge clk) #1;
    acc = 1'h1; // access cycles
    // everything held until ready is seen at an edge
    @(posedge clk);
    while (rdy !== 1'h1 && waits < 20) begin
      waits++;
      @(posedge clk);
    end
    rd = rdata;
    e = err;
    #1;
    sel = 1'h0;
    acc = 1'h0;
    // released lines must not keep a stale value
    addr = ~addr;
    wr = ~wr;
    wdata = ~wdata;
  endtask
endmodule

// file: dbg_bus_completer_tb_top.sv
`timescale 1ns/10ps
module dbg_bus_completer_tb_top;
  import dbg_port_pkg::*;
  // one row per ordinary transfer: direction, address, data, read back
  typedef struct packed {
    logic wr;
    logic [29:0] a;
    logic [31:0] d;
    logic [31:0] q;
  } row_t;
  row_t rows [7] = '{
    '{1'h1, 30'h0000_0000, 32'haaaa_5555, 32'h0},
    '{1'h1, 30'h0000_00ff, 32'h1234_abcd, 32'h0}, // upper bits ignored
    '{1'h0, 30'h2000_0000, 32'h0, 32'haaaa_5555}, // top bit aliases
    '{1'h0, 30'h0000_000f, 32'h0, 32'h1234_abcd},
    '{1'h0, 30'h0000_0005, 32'h0, 32'h0},
    '{1'h1, 30'h0000_0005, 32'hffff_ffff, 32'h0},
    '{1'h0, 30'h0000_0005, 32'h0, 32'hffff_ffff}
  };
  logic clock, rstn, off, sel, acc, wr, rdy, err, e;
  logic [31:2] addr;
  logic [31:0] wdata, rdata, rd;
  int waits, n_mismatch, tests_run;
  // bus clock, 100 ns period
  always #50 clock = ~clock;
  dbg_bus_completer u_dut (.CLOCK(clock), .RSTN(rstn),
    .DBG_BUS_ADDR(addr), .DBG_BUS_SEL(sel), .DBG_BUS_ACCESS_PHASE(acc),
    .DBG_BUS_DIR_WRITE(wr), .DBG_BUS_WR_DATA(wdata), .DBG_COMP_OFF(off),
    .DBG_BUS_RDY(rdy), .DBG_BUS_RD_DATA(rdata), .DBG_BUS_ERR(err));
  dbg_requester u_req (.clk(clock), .addr(addr), .sel(sel), .acc(acc),
    .wr(wr), .wdata(wdata), .rdy(rdy), .rdata(rdata), .err(err));
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // under a hundred cycles are needed; far longer means a hang
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    clock = 1'h0;
    rstn = 1'h0;
    off = 1'h0;
    repeat (10) @(posedge clock);
    #1 rstn = 1'h1;
    repeat (3) @(posedge clock);
    foreach (rows[i]) begin
      u_req.xfer(rows[i].wr, rows[i].a, rows[i].d, rd, e, waits);
      chk(32'(waits), 32'h1); // one stall cycle
      chk(e, 1'h0);
      chk(rdy, 1'h0);
      chk(rdata, 32'h0);
      if (!rows[i].wr)
        chk(rd, rows[i].q);
    end
    // powered down: clamps, and a write that must not land
    off = 1'h1;
    repeat (6) @(posedge clock);
    #1 chk(rdy, 1'h1);
    chk(err, 1'h1);
    chk(rdata, 32'h0);
    u_req.xfer(1'h1, 30'h0, 32'h1234_5678, rd, e, waits);
    chk(e, 1'h1);
    chk(32'(waits), 32'h0);
    chk(rd, 32'h0);
    off = 1'h0;
    repeat (6) @(posedge clock);
    u_req.xfer(1'h0, 30'h0, 32'h0, rd, e, waits);
    chk(rd, 32'haaaa_5555);
    chk(32'(waits), 32'h1);
    chk(e, 1'h0);
    // second reset mid-run idles the port and clears the store
    rstn = 1'h0;
    repeat (2) @(posedge clock);
    #1 chk(rdy, 1'h0);
    chk(err, 1'h0);
    rstn = 1'h1;
    repeat (3) @(posedge clock);
    u_req.xfer(1'h0, 30'h0000_000f, 32'h0, rd, e, waits);
    chk(rd, 32'h0);
    chk(32'(waits), 32'h1);
    report_and_stop;
  end
endmodule
